// ==== design/ckt_regs.svh ====
// constants of the classifier key tag field builder
// assumes a 32-bit classic wishbone register bus and a 200 MHz core clock
// Overview of operation
// - special-source mask layout only when layout select code is 3
// - mask bits 0..3 flag processor ports and virtual devices as source
// - mask bits 4..9 hold source port, masqueraded port when masqueraded
// - mask bits 44..48 pipeline point, 49..51 pipeline action, 52 reserved
// - multicast flag equals destination MAC bit 40
// - broadcast flag set only for the all-ones destination MAC
// - outer protocol code 0 untagged, 1 ctag, 4 stag, 5..7 custom
// - outer priority, drop-eligible, vlan id from frame or classified values
// - outer vlan id is zero for untagged frames
// - second tag protocol code 0 absent, 1, 4, 5..7 as outer
// - second tag priority, drop-eligible, vlan id always from the frame
// - third tag protocol code 0 absent, 1, 4, 5..7 as outer
// - third tag priority, drop-eligible, vlan id copied from frame
`ifndef CKT_REGS_SVH
`define CKT_REGS_SVH

`define CKT_ADR_CTRL 8'h00
`define CKT_ADR_CUST1 8'h04
`define CKT_ADR_CUST2 8'h08
`define CKT_ADR_CUST3 8'h0C
`define CKT_ADR_STATUS 8'h10

`define CKT_CTRL_USE_CL 0
`define CKT_CTRL_CPU_ENA 1
`define CKT_CTRL_VD_ENA 2
`define CKT_CTRL_LBK_ENA 3
`define CKT_CTRL_RESET 4'h0
`define CKT_CUST_RESET 16'h0000

`define CKT_TPID_CTAG 16'h8100
`define CKT_TPID_STAG 16'h88A8

`define CKT_CODE_NONE 3'h0
`define CKT_CODE_CTAG 3'h1
`define CKT_CODE_STAG 3'h4
`define CKT_CODE_CUST1 3'h5
`define CKT_CODE_CUST2 3'h6
`define CKT_CODE_CUST3 3'h7

`define CKT_CODE_RSVD_LO 3'h2
`define CKT_CODE_RSVD_HI 3'h3

`define CKT_MAC_MC_BIT 40
`define CKT_MAC_BCAST 48'hFFFF_FFFF_FFFF

`define CKT_SEL_DEFAULT 2'h0
`define CKT_SEL_SPECIAL 2'h3

`define CKT_MASK_W 53
`define CKT_MB_FIRST_PROCESSOR_PORT 0
`define CKT_MB_SECOND_PROCESSOR_PORT 1
`define CKT_MB_VD0 2
`define CKT_MB_VD1 3
`define CKT_MB_PORT_LO 4
`define CKT_MB_PORT_HI 9
`define CKT_MB_PPT_LO 44
`define CKT_MB_PPT_HI 48
`define CKT_MB_PACT_LO 49
`define CKT_MB_PACT_HI 51

`define CKT_TCI_PCP_HI 15
`define CKT_TCI_PCP_LO 13
`define CKT_TCI_DEI 12
`define CKT_TCI_VID_HI 11

`define CKT_ST_CNT_HI 15
`define CKT_ST_CODE_LO 16
`define CKT_ST_CODE_HI 18
`define CKT_ST_SEL_LO 19
`define CKT_ST_SEL_HI 20

`endif

// ==== design/ckt_pkg.sv ====
// types of the classifier key tag field builder
// assumes ckt_regs.svh is on the include path
package ckt_pkg;
  `include "ckt_regs.svh"

  typedef struct packed {
    logic [2:0] code;
    logic [2:0] pcp;
    logic dei;
    logic [11:0] vid;
  } ckt_tag_t;

  typedef logic [1:0] ckt_sel_t;
endpackage

// ==== design/ckt_cfg_if.sv ====
// configuration carried from the register file to the key builders
// assumes one driver (the top) and any number of readers
`timescale 1ns/1ps
interface ckt_cfg_if;
  logic [2:0][15:0] custom_tpid;
  logic cpu_mask_ena;
  logic vd_mask_ena;
  logic lbk_mask_ena;

  modport drive (
    output custom_tpid,
    output cpu_mask_ena,
    output vd_mask_ena,
    output lbk_mask_ena
  );
  modport use_cfg (
    input custom_tpid,
    input cpu_mask_ena,
    input vd_mask_ena,
    input lbk_mask_ena
  );
endinterface

// ==== design/ckt_tag_enc.sv ====
// encodes one vlan tag into its protocol code and tci fields
// assumes tpid and tci come from the frame parser on the same clock
`timescale 1ns/1ps
`include "ckt_regs.svh"
module ckt_tag_enc
  import ckt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic present_i,
  input wire logic [15:0] tpid_i,
  input wire logic [15:0] tci_i,
  ckt_cfg_if.use_cfg cfg,
  output ckt_tag_t field_o
);
  logic [2:0] code;

  always_comb begin
    code = `CKT_CODE_NONE;
    if (present_i) begin
      if (tpid_i == `CKT_TPID_CTAG) code = `CKT_CODE_CTAG;
      else if (tpid_i == `CKT_TPID_STAG) code = `CKT_CODE_STAG;
      else if (tpid_i == cfg.custom_tpid[0]) code = `CKT_CODE_CUST1;
      else if (tpid_i == cfg.custom_tpid[1]) code = `CKT_CODE_CUST2;
      else if (tpid_i == cfg.custom_tpid[2]) code = `CKT_CODE_CUST3;
    end
    field_o.code = code;
    // unrecognised protocol counts as no tag
    if (code == `CKT_CODE_NONE) begin
      field_o.pcp = 3'h0;
      field_o.dei = 1'b0;
      field_o.vid = 12'h000;
    end else begin
      field_o.pcp = tci_i[`CKT_TCI_PCP_HI:`CKT_TCI_PCP_LO];
      field_o.dei = tci_i[`CKT_TCI_DEI];
      field_o.vid = tci_i[`CKT_TCI_VID_HI:0];
    end
  end

  ctag_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    present_i && tpid_i == `CKT_TPID_CTAG |-> field_o.code == `CKT_CODE_CTAG)
    else $error("ctag protocol not encoded as 1");
  no_rsvd_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    field_o.code != `CKT_CODE_RSVD_LO && field_o.code != `CKT_CODE_RSVD_HI &&
    (field_o.code != `CKT_CODE_NONE || field_o == '0))
    else $error("reserved code or stale fields on absent tag");
endmodule

// ==== design/ckt_mask_build.sv ====
// builds the layout select code and the special-source ingress mask
// assumes port numbers of the special sources are fixed by parameters
`timescale 1ns/1ps
`include "ckt_regs.svh"
module ckt_mask_build
  import ckt_pkg::*;
#(
  parameter logic [5:0] FIRST_PROCESSOR_PORT_PORT = 6'h35,
  parameter logic [5:0] SECOND_PROCESSOR_PORT_PORT = 6'h36,
  parameter logic [5:0] VD0_PORT = 6'h37,
  parameter logic [5:0] VD1_PORT = 6'h38
) (
  ckt_cfg_if.use_cfg cfg,
  input wire logic cpu_injected_i,
  input wire logic from_vd_i,
  input wire logic from_loopback_i,
  input wire logic [5:0] phys_port_i,
  input wire logic masq_i,
  input wire logic [5:0] masq_port_i,
  input wire logic [4:0] pipeline_point_i,
  input wire logic [2:0] pipeline_action_i,
  output ckt_sel_t sel_o,
  output logic [`CKT_MASK_W-1:0] mask_o
);
  always_comb begin
    mask_o = '0;
    sel_o = `CKT_SEL_DEFAULT;
    if ((cpu_injected_i && cfg.cpu_mask_ena) ||
        (from_vd_i && cfg.vd_mask_ena) ||
        (from_loopback_i && cfg.lbk_mask_ena)) begin
      sel_o = `CKT_SEL_SPECIAL;
      mask_o[`CKT_MB_FIRST_PROCESSOR_PORT] = phys_port_i == FIRST_PROCESSOR_PORT_PORT;
      mask_o[`CKT_MB_SECOND_PROCESSOR_PORT] = phys_port_i == SECOND_PROCESSOR_PORT_PORT;
      mask_o[`CKT_MB_VD0] = phys_port_i == VD0_PORT;
      mask_o[`CKT_MB_VD1] = phys_port_i == VD1_PORT;
      mask_o[`CKT_MB_PORT_HI:`CKT_MB_PORT_LO] =
        masq_i ? masq_port_i : phys_port_i;
      mask_o[`CKT_MB_PPT_HI:`CKT_MB_PPT_LO] = pipeline_point_i;
      mask_o[`CKT_MB_PACT_HI:`CKT_MB_PACT_LO] = pipeline_action_i;
    end
  end
endmodule

// ==== design/ckt_key_top.sv ====
// classifier key tag and source-mask field builder with wishbone registers
// assumes parser inputs are on clk_i; frame_valid_i marks one frame a cycle
`timescale 1ns/1ps
`include "ckt_regs.svh"
module ckt_key_top
  import ckt_pkg::*;
#(
  parameter logic [5:0] FIRST_PROCESSOR_PORT_PORT = 6'h35,
  parameter logic [5:0] SECOND_PROCESSOR_PORT_PORT = 6'h36,
  parameter logic [5:0] VD0_PORT = 6'h37,
  parameter logic [5:0] VD1_PORT = 6'h38
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic frame_valid_i,
  input wire logic [47:0] dest_mac_i,
  input wire logic [1:0] tag_count_i,
  input wire logic [2:0][15:0] tag_tpid_i,
  input wire logic [2:0][15:0] tag_tci_i,
  input wire logic [2:0] cl_pcp_i,
  input wire logic cl_dei_i,
  input wire logic [11:0] cl_vid_i,
  input wire logic cpu_injected_i,
  input wire logic from_vd_i,
  input wire logic from_loopback_i,
  input wire logic [5:0] phys_port_i,
  input wire logic masq_i,
  input wire logic [5:0] masq_port_i,
  input wire logic [4:0] pipeline_point_i,
  input wire logic [2:0] pipeline_action_i,
  output logic key_valid_o,
  output logic [1:0] source_mask_layout_select_o,
  output logic [`CKT_MASK_W-1:0] ingress_source_mask_o,
  output logic dest_multicast_flag_o,
  output logic dest_broadcast_flag_o,
  output logic [2:0] outer_tag_protocol_code_o,
  output logic [2:0] outer_tag_priority_o,
  output logic outer_tag_drop_eligible_o,
  output logic [11:0] outer_tag_vlan_id_o,
  output logic [2:0] second_tag_protocol_code_o,
  output logic [2:0] second_tag_priority_o,
  output logic second_tag_drop_eligible_o,
  output logic [11:0] second_tag_vlan_id_o,
  output logic [2:0] third_tag_protocol_code_o,
  output logic [2:0] third_tag_priority_o,
  output logic third_tag_drop_eligible_o,
  output logic [11:0] third_tag_vlan_id_o
);
  ckt_cfg_if cfg ();

  // register file state
  logic [3:0] ctrl_reg;
  logic [3:0] ctrl_next;
  logic [2:0][15:0] cust_reg;
  logic [2:0][15:0] cust_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [31:0] wmask;
  logic [31:0] status;
  logic wr_en;
  logic use_cl;

  // key state
  ckt_tag_t [2:0] enc;
  ckt_tag_t [2:0] tag_reg;
  ckt_tag_t [2:0] tag_next;
  ckt_sel_t sel_c;
  logic [`CKT_MASK_W-1:0] mask_c;
  logic valid_reg;
  logic valid_next;
  ckt_sel_t sel_reg;
  ckt_sel_t sel_next;
  logic [`CKT_MASK_W-1:0] mask_reg;
  logic [`CKT_MASK_W-1:0] mask_next;
  logic mc_reg;
  logic mc_next;
  logic bc_reg;
  logic bc_next;

  assign use_cl = ctrl_reg[`CKT_CTRL_USE_CL];
  assign cfg.custom_tpid = cust_reg;
  assign cfg.cpu_mask_ena = ctrl_reg[`CKT_CTRL_CPU_ENA];
  assign cfg.vd_mask_ena = ctrl_reg[`CKT_CTRL_VD_ENA];
  assign cfg.lbk_mask_ena = ctrl_reg[`CKT_CTRL_LBK_ENA];

  generate
    for (genvar i = 0; i < 3; i++) begin : g_tag
      ckt_tag_enc u_enc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .present_i(tag_count_i > 2'(i)),
        .tpid_i(tag_tpid_i[i]),
        .tci_i(tag_tci_i[i]),
        .cfg(cfg.use_cfg),
        .field_o(enc[i])
      );
    end
    for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b+7:8*b] = {8{wb_sel_i[b]}};
    end
  endgenerate

  ckt_mask_build #(
    .FIRST_PROCESSOR_PORT_PORT(FIRST_PROCESSOR_PORT_PORT),
    .SECOND_PROCESSOR_PORT_PORT(SECOND_PROCESSOR_PORT_PORT),
    .VD0_PORT(VD0_PORT),
    .VD1_PORT(VD1_PORT)
  ) u_mask (
    .cfg(cfg.use_cfg),
    .cpu_injected_i(cpu_injected_i),
    .from_vd_i(from_vd_i),
    .from_loopback_i(from_loopback_i),
    .phys_port_i(phys_port_i),
    .masq_i(masq_i),
    .masq_port_i(masq_port_i),
    .pipeline_point_i(pipeline_point_i),
    .pipeline_action_i(pipeline_action_i),
    .sel_o(sel_c),
    .mask_o(mask_c)
  );

  // wishbone slave: ack one cycle after the request, write at the ack edge
  always_comb begin
    status = '0;
    status[`CKT_ST_CNT_HI:0] = cnt_reg;
    status[`CKT_ST_CODE_HI:`CKT_ST_CODE_LO] = tag_reg[0].code;
    status[`CKT_ST_SEL_HI:`CKT_ST_SEL_LO] = sel_reg;
    wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
    ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
    ctrl_next = ctrl_reg;
    cust_next = cust_reg;
    cnt_next = cnt_reg + 16'(key_valid_o);
    rdat_next = '0;
    case (wb_adr_i)
      `CKT_ADR_CTRL: begin
        rdat_next = {28'h000_0000, ctrl_reg};
        if (wr_en) begin
          ctrl_next = 4'((ctrl_reg & ~wmask[3:0]) | (wb_dat_i[3:0] & wmask[3:0]));
        end
      end
      `CKT_ADR_CUST1, `CKT_ADR_CUST2, `CKT_ADR_CUST3: begin
        rdat_next = {16'h0000, cust_reg[wb_adr_i[3:2] - 2'h1]};
        if (wr_en) begin
          cust_next[wb_adr_i[3:2] - 2'h1] = 16'(
            (cust_reg[wb_adr_i[3:2] - 2'h1] & ~wmask[15:0]) |
            (wb_dat_i[15:0] & wmask[15:0]));
        end
      end
      `CKT_ADR_STATUS: begin
        rdat_next = status;
      end
      default: begin
        rdat_next = '0;
      end
    endcase
    if (!ack_next) rdat_next = '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `CKT_CTRL_RESET;
      cust_reg <= {3{`CKT_CUST_RESET}};
      ack_reg <= 1'b0;
      rdat_reg <= '0;
      cnt_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      cust_reg <= cust_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      cnt_reg <= cnt_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // key fields load on frame_valid_i and hold until the next frame
  always_comb begin
    valid_next = frame_valid_i;
    sel_next = sel_reg;
    mask_next = mask_reg;
    mc_next = mc_reg;
    bc_next = bc_reg;
    tag_next = tag_reg;
    if (frame_valid_i) begin
      sel_next = sel_c;
      mask_next = mask_c;
      mc_next = dest_mac_i[`CKT_MAC_MC_BIT];
      bc_next = dest_mac_i == `CKT_MAC_BCAST;
      tag_next = enc;
      if (use_cl) begin
        tag_next[0].pcp = cl_pcp_i;
        tag_next[0].dei = cl_dei_i;
        tag_next[0].vid = cl_vid_i;
      end
      if (enc[0].code == `CKT_CODE_NONE) begin
        tag_next[0].vid = 12'h000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_reg <= 1'b0;
      sel_reg <= `CKT_SEL_DEFAULT;
      mask_reg <= '0;
      mc_reg <= 1'b0;
      bc_reg <= 1'b0;
      tag_reg <= '0;
    end else begin
      valid_reg <= valid_next;
      sel_reg <= sel_next;
      mask_reg <= mask_next;
      mc_reg <= mc_next;
      bc_reg <= bc_next;
      tag_reg <= tag_next;
    end
  end

  assign key_valid_o = valid_reg;
  assign source_mask_layout_select_o = sel_reg;
  assign ingress_source_mask_o = mask_reg;
  assign dest_multicast_flag_o = mc_reg;
  assign dest_broadcast_flag_o = bc_reg;
  assign outer_tag_protocol_code_o = tag_reg[0].code;
  assign outer_tag_priority_o = tag_reg[0].pcp;
  assign outer_tag_drop_eligible_o = tag_reg[0].dei;
  assign outer_tag_vlan_id_o = tag_reg[0].vid;
  assign second_tag_protocol_code_o = tag_reg[1].code;
  assign second_tag_priority_o = tag_reg[1].pcp;
  assign second_tag_drop_eligible_o = tag_reg[1].dei;
  assign second_tag_vlan_id_o = tag_reg[1].vid;
  assign third_tag_protocol_code_o = tag_reg[2].code;
  assign third_tag_priority_o = tag_reg[2].pcp;
  assign third_tag_drop_eligible_o = tag_reg[2].dei;
  assign third_tag_vlan_id_o = tag_reg[2].vid;

  sel_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_valid_i && cpu_injected_i && ctrl_reg[`CKT_CTRL_CPU_ENA] |=>
    key_valid_o && source_mask_layout_select_o == `CKT_SEL_SPECIAL)
    else $error("enabled injected frame missed layout code 3");
  mask_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
    key_valid_o && source_mask_layout_select_o == `CKT_SEL_SPECIAL |->
    ingress_source_mask_o[`CKT_MB_VD1] == ($past(phys_port_i) == VD1_PORT) &&
    ingress_source_mask_o[`CKT_MB_FIRST_PROCESSOR_PORT] == ($past(phys_port_i) == FIRST_PROCESSOR_PORT_PORT))
    else $error("special source flag bits wrong");
  src_port_a: assert property (@(posedge clk_i) disable iff (rst_i)
    key_valid_o && source_mask_layout_select_o == `CKT_SEL_SPECIAL |->
    ingress_source_mask_o[`CKT_MB_PORT_HI:`CKT_MB_PORT_LO] ==
    ($past(masq_i) ? $past(masq_port_i) : $past(phys_port_i)))
    else $error("source port field wrong");
  pipe_fields_a: assert property (@(posedge clk_i) disable iff (rst_i)
    key_valid_o && source_mask_layout_select_o == `CKT_SEL_SPECIAL |->
    ingress_source_mask_o[`CKT_MB_PACT_HI:`CKT_MB_PPT_LO] ==
    {$past(pipeline_action_i), $past(pipeline_point_i)} &&
    !ingress_source_mask_o[`CKT_MASK_W-1])
    else $error("pipeline fields or reserved bit wrong");
  mc_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_valid_i |=>
    dest_multicast_flag_o == $past(dest_mac_i[`CKT_MAC_MC_BIT]))
    else $error("multicast flag does not follow bit 40");
  bc_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_valid_i |=>
    dest_broadcast_flag_o == ($past(dest_mac_i) == `CKT_MAC_BCAST))
    else $error("broadcast flag does not match all-ones address");
  cl_subst_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_valid_i && use_cl && tag_count_i != 2'h0 &&
    enc[0].code != `CKT_CODE_NONE |=> outer_tag_vlan_id_o == $past(cl_vid_i)
    && outer_tag_priority_o == $past(cl_pcp_i))
    else $error("classified outer values not used");
  untag_vid_a: assert property (@(posedge clk_i) disable iff (rst_i)
    key_valid_o && outer_tag_protocol_code_o == `CKT_CODE_NONE |->
    outer_tag_vlan_id_o == 12'h000)
    else $error("untagged frame with nonzero vlan id");
  inner_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_valid_i && use_cl && tag_count_i > 2'h1 &&
    tag_tpid_i[1] == `CKT_TPID_CTAG |=>
    second_tag_vlan_id_o == $past(tag_tci_i[1][11:0]))
    else $error("second tag not copied from frame");
  third_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_valid_i && tag_count_i == 2'h3 &&
    tag_tpid_i[2] == `CKT_TPID_STAG |=> third_tag_protocol_code_o ==
    `CKT_CODE_STAG && third_tag_priority_o == $past(tag_tci_i[2][15:13]))
    else $error("third tag not copied from frame");
endmodule

// ==== dv/ckt_parser_model.sv ====
// partner model of the frame parser that feeds mac and tag results
// assumes the bench calls send_frame once per frame, all on clk_i
`timescale 1ns/1ps
module ckt_parser_model (
  input wire logic clk_i,
  output logic frame_valid_o,
  output logic [47:0] dest_mac_o,
  output logic [1:0] tag_count_o,
  output logic [2:0][15:0] tag_tpid_o,
  output logic [2:0][15:0] tag_tci_o
);
  initial begin
    frame_valid_o = 1'b0;
    dest_mac_o = 48'h0000_0000_0000;
    tag_count_o = 2'h0;
    tag_tpid_o = '0;
    tag_tci_o = '0;
  end

  task automatic send_frame(input logic [47:0] mac, input logic [1:0] cnt,
                            input logic [47:0] tp, input logic [47:0] tc);
    @(posedge clk_i);
    frame_valid_o <= 1'b1;
    dest_mac_o <= mac;
    tag_count_o <= cnt;
    tag_tpid_o <= tp;
    tag_tci_o <= tc;
    @(posedge clk_i);
    // results are stale now: show their inverse rather than hold them
    frame_valid_o <= 1'b0;
    dest_mac_o <= ~mac;
    tag_count_o <= ~cnt;
    tag_tpid_o <= ~tp;
    tag_tci_o <= ~tc;
  endtask
endmodule

// ==== dv/ckt_key_top_bench.sv ====
// self-checking bench of the key tag and source-mask field builder
// assumes the parser model drives frames and the bench drives the rest
`timescale 1ns/1ps
`include "ckt_regs.svh"
module ckt_key_top_bench;
  import ckt_pkg::*;
  localparam logic [5:0] P_FIRST_PROCESSOR_PORT = 6'h35;
  localparam logic [5:0] P_SECOND_PROCESSOR_PORT = 6'h36;
  localparam logic [5:0] P_VD0 = 6'h37;
  localparam logic [5:0] P_VD1 = 6'h38;
  localparam logic [47:0] TCI = 48'hE789_4456_B123;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, frame_valid_i, cl_dei_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [47:0] dest_mac_i;
  logic [1:0] tag_count_i, source_mask_layout_select_o;
  logic [2:0][15:0] tag_tpid_i, tag_tci_i;
  logic [2:0] cl_pcp_i, pipeline_action_i;
  logic [11:0] cl_vid_i;
  logic cpu_injected_i, from_vd_i, from_loopback_i, masq_i, key_valid_o;
  logic [5:0] phys_port_i, masq_port_i;
  logic [4:0] pipeline_point_i;
  logic [`CKT_MASK_W-1:0] ingress_source_mask_o, m;
  logic dest_multicast_flag_o, dest_broadcast_flag_o;
  logic [2:0] outer_tag_protocol_code_o, outer_tag_priority_o;
  logic [2:0] second_tag_protocol_code_o, second_tag_priority_o;
  logic [2:0] third_tag_protocol_code_o, third_tag_priority_o;
  logic outer_tag_drop_eligible_o, second_tag_drop_eligible_o;
  logic third_tag_drop_eligible_o;
  logic [11:0] outer_tag_vlan_id_o, second_tag_vlan_id_o, third_tag_vlan_id_o;
  logic [18:0] key_tag [3];
  logic [15:0] tp_tab [6] = '{16'h8100, 16'h88A8, 16'h9100, 16'h9200,
                              16'h9300, 16'h1234};
  logic [2:0] cd_tab [6] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
  logic [47:0] mac_tab [4] = '{48'hFFFF_FFFF_FFFF, 48'h0100_0000_0000,
                               48'hFFFF_FFFF_FFFE, 48'hFEFF_FFFF_FFFF};
  logic [1:0] mcbc_tab [4] = '{2'h3, 2'h2, 2'h2, 2'h0};
  logic [5:0] pt_tab [4] = '{P_FIRST_PROCESSOR_PORT, P_SECOND_PROCESSOR_PORT, P_VD0, P_VD1};
  int num_errors = 0;
  int checks_done = 0;
  int nkeys = 0;

  assign key_tag[0] = {outer_tag_protocol_code_o, outer_tag_priority_o,
                       outer_tag_drop_eligible_o, outer_tag_vlan_id_o};
  assign key_tag[1] = {second_tag_protocol_code_o, second_tag_priority_o,
                       second_tag_drop_eligible_o, second_tag_vlan_id_o};
  assign key_tag[2] = {third_tag_protocol_code_o, third_tag_priority_o,
                       third_tag_drop_eligible_o, third_tag_vlan_id_o};

  always #2.5 clk_i = ~clk_i;

  ckt_parser_model ckt_parser_model_i (.clk_i, .frame_valid_o(frame_valid_i),
    .dest_mac_o(dest_mac_i), .tag_count_o(tag_count_i),
    .tag_tpid_o(tag_tpid_i), .tag_tci_o(tag_tci_i));

  ckt_key_top #(.FIRST_PROCESSOR_PORT_PORT(P_FIRST_PROCESSOR_PORT), .SECOND_PROCESSOR_PORT_PORT(P_SECOND_PROCESSOR_PORT), .VD0_PORT(P_VD0),
    .VD1_PORT(P_VD1)) ckt_key_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .frame_valid_i, .dest_mac_i, .tag_count_i, .tag_tpid_i, .tag_tci_i,
    .cl_pcp_i, .cl_dei_i, .cl_vid_i, .cpu_injected_i, .from_vd_i,
    .from_loopback_i, .phys_port_i, .masq_i, .masq_port_i, .pipeline_point_i,
    .pipeline_action_i, .key_valid_o, .source_mask_layout_select_o,
    .ingress_source_mask_o, .dest_multicast_flag_o, .dest_broadcast_flag_o,
    .outer_tag_protocol_code_o, .outer_tag_priority_o,
    .outer_tag_drop_eligible_o, .outer_tag_vlan_id_o,
    .second_tag_protocol_code_o, .second_tag_priority_o,
    .second_tag_drop_eligible_o, .second_tag_vlan_id_o,
    .third_tag_protocol_code_o, .third_tag_priority_o,
    .third_tag_drop_eligible_o, .third_tag_vlan_id_o);

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // one classic cycle; the request holds until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      test_done();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk("register read", e, q);
  endtask

  task automatic frame(input logic [47:0] mac, input logic [1:0] cnt,
                       input logic [47:0] tp);
    ckt_parser_model_i.send_frame(mac, cnt, tp, TCI);
    nkeys++;
    #1;
    chk("key valid", 64'h1, key_valid_o);
  endtask

  task automatic chk_tags(input logic [1:0] cnt, input logic [8:0] cd);
    for (int t = 0; t < 3; t++) begin
      chk("tag fields", (t < cnt) ? {cd[t*3+:3], TCI[t*16+:16]} : 19'h0,
          key_tag[t]);
    end
  endtask

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, cpu_injected_i, from_vd_i} = '0;
    {from_loopback_i, masq_i, cl_dei_i} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, cl_pcp_i, cl_vid_i, phys_port_i} = '0;
    {masq_port_i, pipeline_point_i, pipeline_action_i} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 6; a++) begin
      rd_chk(8'(a * 4), 32'h0000_0000);
    end
    wb(1'b1, 8'h14, 32'hFFFF_FFFF);
    rd_chk(8'h14, 32'h0000_0000);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, 8'(4 + i * 4), {16'h0000, tp_tab[i + 2]});
      rd_chk(8'(4 + i * 4), {16'h0000, tp_tab[i + 2]});
    end
    for (int i = 0; i < 6; i++) begin
      frame(48'h0000_0000_0001, 2'h3, {3{tp_tab[i]}});
      chk_tags((i == 5) ? 2'h0 : 2'h3, {3{cd_tab[i]}});
    end
    frame(48'h0000_0000_0001, 2'h2, {16'h9300, 16'h88A8, 16'h8100});
    chk_tags(2'h2, {3'h7, 3'h4, 3'h1});
    frame(48'h0000_0000_0001, 2'h0, {3{16'h8100}});
    chk_tags(2'h0, 9'h000);
    for (int i = 0; i < 4; i++) begin
      frame(mac_tab[i], 2'h0, {3{16'h8100}});
      chk("mc bc", mcbc_tab[i], {dest_multicast_flag_o, dest_broadcast_flag_o});
    end
    @(posedge clk_i);
    #1;
    chk("key valid low", 64'h0, key_valid_o);
    chk("mc bc hold", 2'h0, {dest_multicast_flag_o, dest_broadcast_flag_o});
    wb(1'b1, 8'h00, 32'h0000_0001);
    rd_chk(8'h00, 32'h0000_0001);
    @(posedge clk_i);
    cl_pcp_i <= 3'h2;
    cl_dei_i <= 1'b1;
    cl_vid_i <= 12'hABC;
    frame(48'h0000_0000_0001, 2'h2, {16'h9300, 16'h8100, 16'h88A8});
    chk("outer classified", {3'h4, 3'h2, 1'b1, 12'hABC}, key_tag[0]);
    chk("second from frame", {3'h1, TCI[31:16]}, key_tag[1]);
    frame(48'h0000_0000_0001, 2'h0, {3{16'h8100}});
    chk("untagged classified", {3'h0, 3'h2, 1'b1, 12'h000}, key_tag[0]);
    @(posedge clk_i);
    cpu_injected_i <= 1'b1;
    phys_port_i <= P_FIRST_PROCESSOR_PORT;
    pipeline_point_i <= 5'h15;
    pipeline_action_i <= 3'h6;
    masq_port_i <= 6'h0A;
    wb(1'b1, 8'h00, 32'h0000_0000);
    frame(48'h0000_0000_0001, 2'h0, {3{16'h8100}});
    chk("select off", 2'h0, source_mask_layout_select_o);
    chk("mask off", 53'h0, ingress_source_mask_o);
    wb(1'b1, 8'h00, 32'h0000_000E);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      cpu_injected_i <= (k < 2);
      from_vd_i <= (k == 2);
      from_loopback_i <= (k == 3);
      masq_i <= (k == 3);
      phys_port_i <= pt_tab[k];
      frame(48'h0000_0000_0001, 2'h0, {3{16'h8100}});
      m = '0;
      m[k] = 1'b1;
      m[9:4] = (k == 3) ? 6'h0A : pt_tab[k];
      m[48:44] = 5'h15;
      m[51:49] = 3'h6;
      chk("select special", 2'h3, source_mask_layout_select_o);
      chk("special mask", m, ingress_source_mask_o);
    end
    rd_chk(8'h10, {11'h000, 2'h3, 3'h0, 16'(nkeys)});
    test_done();
  end
endmodule
